/* verilog/apm_ctrl.sv */
// Purpose: power, clock-mode and shutdown control of a serial converter
// Assumes: sclk, cs_n and din are synchronous to aclk; sclk below aclk/4
// Notes:   registers over AXI4-Lite; shutdown pin low is the strongest event
// Functional notes
// - after reset: internal clock mode, ready, strobe driven high
// - until a first conversion completes, or starts in external mode, serial output shifts zeros
// - floating shutdown pin selects external compensation, clock up to 2MHz
// - shutdown pin low forces full sleep over software power bits
// - power bits: 00 deep, 01 light, 10 internal clock, 11 external
// - sleep request finishes current conversion in old mode, then sleeps
// - internal mode: stored result still shifts out while asleep
// - software sleep keeps serial interface, performs no conversion
// - high power bit set stays awake, clear sleeps after one conversion
// - first one on data in is start bit, wakes device, opens byte
// - shutdown pin low aborts a running conversion immediately
// - after shutdown release no wake-up delay is imposed by the device
// - conversion starts on serial clock fall after the eighth byte bit
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
module apm_ctrl
  import apm_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial port
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  output logic             conversion_strobe_out,
  output logic             conversion_strobe_oe,
  // shutdown pin: level sensed and floating detected
  input  wire logic        hard_shutdown_pin,
  input  wire logic        hard_shutdown_float,
  // analog side
  input  wire logic [11:0] sar_code,
  output logic             comp_ext_sel,
  output logic             core_power_on,
  output logic             ref_power_on
);

  function automatic logic addr_known(input logic [7:0] a);
    return (a == REG_STATUS) || (a == REG_CTRL_BYTE) ||
           (a == REG_RESULT) || (a == REG_CONV_LEN);
  endfunction

  // core state
  apm_pwr_e    pwr_q,      pwr_d;
  apm_pwr_e    slp_mode_q, slp_mode_d;
  logic        clk_ext_q,  clk_ext_d;
  logic        sclk_q;
  logic        rx_act_q,   rx_act_d;
  logic [2:0]  rx_cnt_q,   rx_cnt_d;
  logic [7:0]  rx_byte_q,  rx_byte_d;
  logic        byte_rdy_q, byte_rdy_d;
  logic        slp_after_q, slp_after_d;
  logic        first_q,    first_d;
  logic [15:0] por_q,      por_d;
  logic [15:0] per_q,      per_d;
  logic [7:0]  last_q,     last_d;
  logic [15:0] out_sh_q,   out_sh_d;
  logic        dout_q,     dout_d;
  logic        strb_q,     strb_d;
  logic        strb_oe_q,  strb_oe_d;
  logic        comp_q;
  logic        fast_q,     fast_d;
  logic        slow_q,     slow_d;
  logic        early_q,    early_d;
  logic [15:0] conv_len_q, conv_len_d;

  // bus state
  logic        aw_got_q, aw_got_d;
  logic        w_got_q,  w_got_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q,  wdata_d;
  logic [3:0]  wstrb_q,  wstrb_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q,  bresp_d;
  logic        rvalid_q, rvalid_d;
  logic [1:0]  rresp_q,  rresp_d;
  logic [31:0] rdata_q,  rdata_d;

  logic           rise, fall, halt, wr_fire;
  logic [2:0]     clr_bits;
  logic [31:0]    status_word;
  apm_conv_cmd_s  cmd;
  apm_conv_stat_s cst;

  assign rise    = sclk & ~sclk_q;
  assign fall    = ~sclk & sclk_q;
  assign halt    = ~hard_shutdown_pin;
  assign wr_fire = aw_got_q & w_got_q & ~bvalid_q;
  assign clr_bits = (wr_fire && awaddr_q == REG_STATUS && wstrb_q[1]) ?
                    {wdata_q[ST_EARLY], wdata_q[ST_SLOW], wdata_q[ST_FAST]} :
                    3'b000;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_PWR_LO +: 2] = pwr_q;
    status_word[ST_CLK_EXT] = clk_ext_q;
    status_word[ST_BUSY]    = cst.busy;
    status_word[ST_FIRST]   = first_q;
    status_word[ST_COMP]    = comp_q;
    status_word[ST_POR]     = (por_q != 16'h0000);
    status_word[ST_FAST]    = fast_q;
    status_word[ST_SLOW]    = slow_q;
    status_word[ST_EARLY]   = early_q;
  end

  apm_conv_seq u_conv (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .cmd      (cmd),
    .conv_len (conv_len_q),
    .sar_code (sar_code),
    .stat     (cst)
  );

  // core next-state
  always_comb begin
    pwr_d       = pwr_q;
    slp_mode_d  = slp_mode_q;
    clk_ext_d   = clk_ext_q;
    rx_act_d    = rx_act_q;
    rx_cnt_d    = rx_cnt_q;
    rx_byte_d   = rx_byte_q;
    byte_rdy_d  = byte_rdy_q;
    slp_after_d = slp_after_q;
    first_d     = first_q;
    por_d       = (por_q != 16'h0000) ? por_q - 16'h0001 : por_q;
    per_d       = (per_q != 16'hFFFF) ? per_q + 16'h0001 : per_q;
    last_d      = last_q;
    out_sh_d    = out_sh_q;
    dout_d      = dout_q;
    fast_d      = fast_q & ~clr_bits[0];
    slow_d      = slow_q & ~clr_bits[1];
    early_d     = early_q & ~clr_bits[2];
    cmd         = '0;
    cmd.sclk_fall = fall;
    cmd.ext_mode  = clk_ext_q;

    if (rise && !cs_n && !rx_act_q && !byte_rdy_q && !cst.busy && din) begin
      rx_act_d  = 1'b1;
      rx_cnt_d  = 3'h1;
      rx_byte_d = 8'h01;
      pwr_d     = APM_AWAKE;
      if (por_q != 16'h0000) begin
        early_d = 1'b1;
      end
    end else if (rise && !cs_n && rx_act_q) begin
      rx_byte_d = {rx_byte_q[6:0], din};
      rx_cnt_d  = rx_cnt_q + 3'h1;
      if (rx_cnt_q == CTRL_LAST_BIT) begin
        rx_act_d   = 1'b0;
        byte_rdy_d = 1'b1;
      end
    end

    if (fall && byte_rdy_q) begin
      byte_rdy_d = 1'b0;
      last_d     = rx_byte_q;
      per_d      = 16'h0000;
      cmd.start  = (pwr_q == APM_AWAKE);
      if (rx_byte_q[1]) begin
        clk_ext_d    = rx_byte_q[0];
        cmd.ext_mode = rx_byte_q[0];
        slp_after_d  = 1'b0;
      end else begin
        slp_after_d = 1'b1;
        slp_mode_d  = rx_byte_q[0] ? APM_LIGHT : APM_DEEP;
      end
    end

    // serial clock period check while the serial clock drives conversion
    if (fall && cst.busy && clk_ext_q && !cmd.start) begin
      per_d = 16'h0000;
      if (per_q < (comp_q ? SCLK_EXT_MIN_CYC : SCLK_INT_MIN_CYC)) begin
        fast_d = 1'b1;
      end
      if (per_q > SCLK_MAX_CYC) begin
        slow_d = 1'b1;
      end
    end

    if (fall && !cs_n) begin
      dout_d   = out_sh_q[15];
      out_sh_d = {out_sh_q[14:0], 1'b0};
    end
    if (cst.load) begin
      out_sh_d = {cst.code, 4'h0};
    end

    if (cst.done) begin
      first_d = 1'b1;
      if (slp_after_q) begin
        pwr_d       = slp_mode_q;
        slp_after_d = 1'b0;
      end
    end

    if (halt) begin
      pwr_d       = APM_DEEP;
      rx_act_d    = 1'b0;
      byte_rdy_d  = 1'b0;
      slp_after_d = 1'b0;
      cmd.start   = 1'b0;
      cmd.abort   = 1'b1;
    end

    // internal mode keeps the strobe driven even with chip select high
    if (clk_ext_q) begin
      strb_d    = cst.ext_pulse;
      strb_oe_d = ~cs_n;
    end else begin
      strb_d    = ~cst.busy;
      strb_oe_d = 1'b1;
    end
  end

  // bus next-state
  always_comb begin
    aw_got_d   = aw_got_q;
    w_got_d    = w_got_q;
    awaddr_d   = awaddr_q;
    wdata_d    = wdata_q;
    wstrb_d    = wstrb_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    rvalid_d   = rvalid_q;
    rresp_d    = rresp_q;
    rdata_d    = rdata_q;
    conv_len_d = conv_len_q;
    if (s_axi_awvalid && !aw_got_q && !bvalid_q) begin
      aw_got_d = 1'b1;
      awaddr_d = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && !w_got_q && !bvalid_q) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = addr_known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      if (awaddr_q == REG_CONV_LEN) begin
        if (wstrb_q[0]) conv_len_d[7:0]  = wdata_q[7:0];
        if (wstrb_q[1]) conv_len_d[15:8] = wdata_q[15:8];
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = addr_known({s_axi_araddr[7:2], 2'b00}) ?
                 RESP_OKAY : RESP_SLVERR;
      unique case ({s_axi_araddr[7:2], 2'b00})
        REG_STATUS:    rdata_d = status_word;
        REG_CTRL_BYTE: rdata_d = {24'h000000, last_q};
        REG_RESULT:    rdata_d = {20'h00000, cst.code};
        REG_CONV_LEN:  rdata_d = {16'h0000, conv_len_q};
        default:       rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_q       <= APM_AWAKE;
      clk_ext_q   <= 1'b0;
      strb_q      <= 1'b1;
      strb_oe_q   <= 1'b1;
      slp_mode_q  <= APM_DEEP;
      sclk_q      <= 1'b0;
      rx_act_q    <= 1'b0;
      rx_cnt_q    <= 3'h0;
      rx_byte_q   <= 8'h00;
      byte_rdy_q  <= 1'b0;
      slp_after_q <= 1'b0;
      first_q     <= 1'b0;
      por_q       <= POR_CYCLES;
      per_q       <= 16'h0000;
      last_q      <= 8'h00;
      out_sh_q    <= 16'h0000;
      dout_q      <= 1'b0;
      comp_q      <= 1'b0;
      fast_q      <= 1'b0;
      slow_q      <= 1'b0;
      early_q     <= 1'b0;
      conv_len_q  <= CONV_LEN_RST;
      aw_got_q    <= 1'b0;
      w_got_q     <= 1'b0;
      awaddr_q    <= 8'h00;
      wdata_q     <= 32'h0000_0000;
      wstrb_q     <= 4'h0;
      bvalid_q    <= 1'b0;
      bresp_q     <= RESP_OKAY;
      rvalid_q    <= 1'b0;
      rresp_q     <= RESP_OKAY;
      rdata_q     <= 32'h0000_0000;
    end else begin
      pwr_q       <= halt ? APM_DEEP : pwr_d;
      clk_ext_q   <= clk_ext_d;
      strb_q      <= strb_d;
      strb_oe_q   <= strb_oe_d;
      slp_mode_q  <= slp_mode_d;
      sclk_q      <= sclk;
      rx_act_q    <= rx_act_d;
      rx_cnt_q    <= rx_cnt_d;
      rx_byte_q   <= rx_byte_d;
      byte_rdy_q  <= byte_rdy_d;
      slp_after_q <= slp_after_d;
      first_q     <= first_d;
      por_q       <= por_d;
      per_q       <= per_d;
      last_q      <= last_d;
      out_sh_q    <= out_sh_d;
      dout_q      <= dout_d;
      comp_q      <= hard_shutdown_float;
      fast_q      <= fast_d;
      slow_q      <= slow_d;
      early_q     <= early_d;
      conv_len_q  <= conv_len_d;
      aw_got_q    <= aw_got_d;
      w_got_q     <= w_got_d;
      awaddr_q    <= awaddr_d;
      wdata_q     <= wdata_d;
      wstrb_q     <= wstrb_d;
      bvalid_q    <= bvalid_d;
      bresp_q     <= bresp_d;
      rvalid_q    <= rvalid_d;
      rresp_q     <= rresp_d;
      rdata_q     <= rdata_d;
    end
  end

  assign s_axi_awready         = ~aw_got_q & ~bvalid_q;
  assign s_axi_wready          = ~w_got_q & ~bvalid_q;
  assign s_axi_bvalid          = bvalid_q;
  assign s_axi_bresp           = bresp_q;
  assign s_axi_arready         = ~rvalid_q;
  assign s_axi_rvalid          = rvalid_q;
  assign s_axi_rresp           = rresp_q;
  assign s_axi_rdata           = rdata_q;
  assign dout                  = dout_q;
  assign dout_oe               = ~cs_n;
  assign conversion_strobe_out = strb_q;
  assign conversion_strobe_oe  = strb_oe_q;
  assign comp_ext_sel          = comp_q;
  assign core_power_on         = (pwr_q == APM_AWAKE);
  assign ref_power_on          = (pwr_q != APM_DEEP);

endmodule

/* verilog/apm_pkg.sv */
// Purpose: shared constants and types for the converter power-mode control
// Assumes: 40 MHz aclk, 32-bit AXI4-Lite register access
// Notes:   all times are kept in their own unit, cycle counts derive from them
package apm_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_NS = 25;

  // register byte offsets
  localparam logic [7:0] REG_STATUS    = 8'h00;
  localparam logic [7:0] REG_CTRL_BYTE = 8'h04;
  localparam logic [7:0] REG_RESULT    = 8'h08;
  localparam logic [7:0] REG_CONV_LEN  = 8'h0C;

  // status field positions
  localparam int unsigned ST_PWR_LO  = 0;
  localparam int unsigned ST_CLK_EXT = 2;
  localparam int unsigned ST_BUSY    = 3;
  localparam int unsigned ST_FIRST   = 4;
  localparam int unsigned ST_COMP    = 5;
  localparam int unsigned ST_POR     = 6;
  localparam int unsigned ST_FAST    = 8;
  localparam int unsigned ST_SLOW    = 9;
  localparam int unsigned ST_EARLY   = 10;

  // power-on reset interval, exact cycle count
  localparam int unsigned POR_TIME_US = 100;
  localparam logic [15:0] POR_CYCLES  =
    16'(POR_TIME_US * 1000 / CLK_PERIOD_NS);

  // internal conversion length, longest time so rounded down
  localparam int unsigned CONV_TIME_NS  = 10000;
  localparam logic [15:0] CONV_LEN_RST  = 16'(CONV_TIME_NS / CLK_PERIOD_NS);

  // serial clock limits: least periods rounded up, longest rounded down
  localparam int unsigned SCLK_INT_MIN_NS = 2500;
  localparam int unsigned SCLK_EXT_MIN_NS = 500;
  localparam int unsigned SCLK_MAX_NS     = 10000;
  localparam logic [15:0] SCLK_INT_MIN_CYC =
    16'((SCLK_INT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] SCLK_EXT_MIN_CYC =
    16'((SCLK_EXT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] SCLK_MAX_CYC = 16'(SCLK_MAX_NS / CLK_PERIOD_NS);

  // serial framing
  localparam logic [2:0] CTRL_LAST_BIT = 3'h7;
  localparam logic [3:0] EXT_FALLS     = 4'hD;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    APM_DEEP  = 2'b00,
    APM_LIGHT = 2'b01,
    APM_AWAKE = 2'b10
  } apm_pwr_e;

  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_INT  = 2'b01,
    CV_EXT  = 2'b10
  } apm_cv_e;

  typedef struct packed {
    logic start;
    logic ext_mode;
    logic abort;
    logic sclk_fall;
  } apm_conv_cmd_s;

  typedef struct packed {
    logic        busy;
    logic        ext_pulse;
    logic        load;
    logic        done;
    logic [11:0] code;
  } apm_conv_stat_s;

endpackage

/* verilog/apm_conv_seq.sv */
// Purpose: conversion sequencer for internal and serial-clocked conversions
// Assumes: sclk_fall is a one-cycle pulse already qualified by the caller
// Notes:   abort wins over every other event and returns to idle at once
module apm_conv_seq
  import apm_pkg::*;
(
  // clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // control
  input  wire apm_conv_cmd_s   cmd,
  input  wire logic [15:0]     conv_len,
  input  wire logic [11:0]     sar_code,
  // result
  output apm_conv_stat_s       stat
);

  apm_cv_e     st_q,   st_d;
  logic [15:0] cnt_q,  cnt_d;
  logic [11:0] code_q, code_d;
  logic        load_q, load_d;
  logic        done_q, done_d;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    code_d = code_q;
    load_d = 1'b0;
    done_d = 1'b0;
    if (cmd.abort) begin
      st_d  = CV_IDLE;
      cnt_d = 16'h0000;
    end else begin
      unique case (st_q)
        CV_IDLE: begin
          if (cmd.start) begin
            cnt_d = 16'h0000;
            st_d  = cmd.ext_mode ? CV_EXT : CV_INT;
            if (cmd.ext_mode) begin
              // serial-clocked result is handed to the shifter up front
              code_d = sar_code;
              load_d = 1'b1;
            end
          end
        end
        CV_INT: begin
          cnt_d = cnt_q + 16'h0001;
          // a zero length still takes one cycle
          if (cnt_d >= conv_len) begin
            code_d = sar_code;
            load_d = 1'b1;
            done_d = 1'b1;
            st_d   = CV_IDLE;
          end
        end
        CV_EXT: begin
          if (cmd.sclk_fall) begin
            cnt_d = cnt_q + 16'h0001;
            if (cnt_d[3:0] == EXT_FALLS - 4'h1) begin
              done_d = 1'b1;
              st_d   = CV_IDLE;
            end
          end
        end
        default: st_d = CV_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q   <= CV_IDLE;
      cnt_q  <= 16'h0000;
      code_q <= 12'h000;
      load_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      code_q <= code_d;
      load_q <= load_d;
      done_q <= done_d;
    end
  end

  // one driver for the whole struct keeps strict tools content
  assign stat = '{busy:      (st_q != CV_IDLE),
                  ext_pulse: (st_q == CV_EXT) && (cnt_q == 16'h0000),
                  load:      load_q,
                  done:      done_q,
                  code:      code_q};

endmodule

/* tb/apm_asserts.sv */
// Purpose: port-level checks of the power-mode control
// Assumes: single aclk domain, synchronous active-low reset
// Notes:   sees only the top module ports, attached by bind
module apm_asserts
  import apm_pkg::*;
(
  // clock and reset
  input wire logic        aclk, aresetn,
  // register bus
  input wire logic [7:0]  s_axi_awaddr, s_axi_araddr,
  input wire logic [31:0] s_axi_wdata, s_axi_rdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
  input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic        s_axi_rready,
  // serial port and pins
  input wire logic        sclk, cs_n, din, dout, dout_oe,
  input wire logic        conversion_strobe_out, conversion_strobe_oe,
  input wire logic        hard_shutdown_pin, hard_shutdown_float,
  input wire logic [11:0] sar_code,
  input wire logic        comp_ext_sel, core_power_on, ref_power_on
);
  timeunit 1ns;
  timeprecision 100ps;

  logic seen_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // any strobe movement marks the first conversion under way
  always_ff @(posedge aclk) begin
    seen_q <= aresetn && (seen_q || !$stable(conversion_strobe_out));
  end

  chk_reset_ready: assert property ($rose(aresetn) |->
    conversion_strobe_out && conversion_strobe_oe && core_power_on)
    else $error("not ready in internal mode after reset");
  chk_zero_out: assert property (dout_oe && !seen_q |-> !dout)
    else $error("serial output not zero before first conversion");
  chk_halt_deep: assert property (!hard_shutdown_pin |=>
    !core_power_on && !ref_power_on)
    else $error("shutdown pin low did not force deep sleep");
  chk_sleep_idle: assert property (!core_power_on |=>
    !$fell(conversion_strobe_out))
    else $error("conversion started while asleep");
  chk_wake_sel: assert property ($rose(core_power_on) |->
    !$past(cs_n))
    else $error("woke up without chip select low");
  chk_port_live: assert property (!cs_n |-> dout_oe)
    else $error("serial output not driven while selected");
  chk_comp_sel: assert property ($past(aresetn) &&
    hard_shutdown_float == $past(hard_shutdown_float) |->
    comp_ext_sel == hard_shutdown_float)
    else $error("compensation select does not follow pin");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");

  cover property ($fell(hard_shutdown_pin));
  cover property ($fell(conversion_strobe_out));
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

bind apm_ctrl apm_asserts apm_asserts_i (.*);

/* tb/apm_host.sv */
// Purpose: serial master model on the far side of the converter port
// Assumes: driven from the bench at rising aclk edges
// Notes:   sclk stands low outside frames; din toggles while deselected
module apm_host (
  // clock and returned data
  input  wire logic aclk,
  input  wire logic dout,
  // serial master outputs
  output logic      sclk,
  output logic      cs_n,
  output logic      din
);
  timeunit 1ns;
  timeprecision 100ps;

  int half = 60;
  int wake_cyc = 200;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  // no stale data line while deselected
  always @(posedge aclk) begin
    if (cs_n) din <= ~din;
  end

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    if (cs_n) begin
      cs_n <= 1'b0;
      repeat (wake_cyc + 1) @(posedge aclk);
    end
    for (int i = 7; i >= 0; i--) begin
      din <= tx[i];
      repeat (half) @(posedge aclk);
      sclk <= 1'b1;
      rx[i] = dout;
      repeat (half) @(posedge aclk);
      sclk <= 1'b0;
    end
  endtask

  task automatic finish();
    repeat (half) @(posedge aclk);
    cs_n <= 1'b1;
    // a next frame must see the deselect before it tests cs_n
    @(posedge aclk);
  endtask
endmodule

/* tb/tb_top.sv */
// Purpose: self-checking bench of the power-mode control
// Assumes: 40 MHz aclk, fixed xorshift seed
// Notes:   results come back over the serial port and the register bus
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import apm_pkg::*;

  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        sclk, cs_n, din, dout, dout_oe;
  logic        conversion_strobe_out, conversion_strobe_oe;
  logic        hard_shutdown_pin = 1'b1, hard_shutdown_float = 1'b0;
  logic [11:0] sar_code = '0;
  logic        comp_ext_sel, core_power_on, ref_power_on;
  logic [31:0] seed = 32'hB9E45110, d;
  logic [1:0]  r;
  logic [7:0]  b0, b1;
  logic        ext = 1'b0;
  int          err_total = 0, n_checks = 0;
  logic [1:0]  pds [6] = '{2'b10, 2'b00, 2'b01, 2'b11, 2'b01, 2'b10};

  always #12.5 aclk = ~aclk;

  apm_ctrl apm_ctrl_i (.*);
  apm_host apm_host_i (.aclk(aclk), .dout(dout), .sclk(sclk),
                       .cs_n(cs_n), .din(din));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // power bits map to the power state; sleep keeps the old clock mode
  function automatic logic [10:0] exp_st(input logic [1:0] pd,
                                         input logic e, input logic c);
    return {5'b00000, c, 2'b10, e, pd[1] ? 2'b10 : pd};
  endfunction

  task automatic check(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 500);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 500) err_total++;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 500);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 500) err_total++;
  endtask

  // one control byte, then two bytes to finish and read back
  task automatic convert(input logic [1:0] pd);
    logic [11:0] code;
    seed = xs(seed);
    code = seed[11:0];
    sar_code <= code;
    apm_host_i.xfer({1'b1, seed[20:16], pd}, b0);
    apm_host_i.xfer(8'h00, b0);
    apm_host_i.xfer(8'h00, b1);
    apm_host_i.finish();
    ext = pd[1] ? pd[0] : ext;
    d = 32'({b0, b1} >> 3) & 32'hFFF;
    check("dout_code", 32'(code), d);
    rd(REG_RESULT, d, r);
    check("result", 32'(code), d & 32'hFFF);
    rd(REG_STATUS, d, r);
    d &= 32'h7FF;
    check("status", 32'(exp_st(pd, ext, hard_shutdown_float)), d);
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(REG_STATUS, d, r);
    check("st_reset", 32'h52 & 32'h4F, d & 32'h4F);
    apm_host_i.xfer(8'h00, b0);
    apm_host_i.xfer(8'h00, b1);
    apm_host_i.finish();
    check("dout_zero", 32'h0, 32'({b0, b1}));
    // no request inside the reset interval
    repeat (POR_CYCLES) @(posedge aclk);
    wr(REG_CONV_LEN, 32'hA, r);
    check("wr_resp", 32'(RESP_OKAY), 32'(r));
    foreach (pds[k]) convert(pds[k]);
    wr(REG_CONV_LEN, 32'h7D0, r);
    apm_host_i.xfer(8'h82, b0);
    repeat (30) @(posedge aclk);
    hard_shutdown_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(REG_STATUS, d, r);
    check("st_halt", 32'h0, d & 32'hF);
    wr(REG_CONV_LEN, 32'hA, r);
    hard_shutdown_pin <= 1'b1;
    apm_host_i.finish();
    convert(2'b10);
    rd(8'h10, d, r);
    check("bad_rd", 32'(RESP_SLVERR), 32'(r));
    check("bad_rdata", 32'h0, d);
    wr(8'h10, 32'h1, r);
    check("bad_wr", 32'(RESP_SLVERR), 32'(r));
    hard_shutdown_float <= 1'b1;
    apm_host_i.half = 12;
    apm_host_i.wake_cyc = 2000; // external comp wait
    repeat (3) @(posedge aclk);
    convert(2'b11);
    summarize();
  end

  initial begin
    repeat (80000) @(posedge aclk);
    err_total++;
    summarize();
  end
endmodule
